// ---- core/usart_defines.svh ----
// constants shared by both ends of the serial link
//
// Summary of operation
// - async shift register loads only after stop bit
// - buffer to shifter in one cycle, flag set
// - tx flag set always, cleared only by write
// - tx request gated by its enable
// - shift empty status bit, polled only
// - enabling transmitter sets tx flag
// - software setup order before transmit enable
// - ninth bit sent from its field
// - buffer write starts a transmission
// - sync master link is half duplex
// - clocked mode turns pins into clock, data
// - clock source select makes device master
// - sync reload only after last data bit
// - either receive enable starts reception
// - master samples data on falling clock
// - single one word, continuous wins over single
// - word done sets rx flag, gated request
// - read status before receive buffer
// - clearing continuous enable clears errors
// - both receive enables clear before selecting
// - clock source clear enters slave mode
// - async frame start, 8/9 lsb first, stop
// - async oversampling 16 or 64 per bit
`ifndef USART_DEFINES_SVH
`define USART_DEFINES_SVH

// device register indices
`define IDX_TX_CONTROL_STATUS 3'h0
`define IDX_RX_CONTROL_STATUS 3'h1
`define IDX_TX_BUFFER 3'h2
`define IDX_RX_BUFFER 3'h3
`define IDX_BAUD_DIVISOR 3'h4
`define IDX_IRQ_FLAGS 3'h5
`define IDX_IRQ_ENABLES 3'h6
`define IDX_IRQ_PRIORITY 3'h7

// tx_control_status fields
`define TXS_CLOCK_SOURCE 7
`define TXS_NINE_BIT 6
`define TXS_TX_ENABLE 5
`define TXS_CLOCKED_MODE 4
`define TXS_ADDRESS_DETECT 3
`define TXS_HIGH_SPEED 2
`define TXS_SHIFT_EMPTY 1
`define TXS_NINTH_BIT 0
`define TXS_RESET 8'h02

// rx_control_status fields
`define RXS_PORT_ENABLE 7
`define RXS_NINE_BIT 6
`define RXS_SINGLE 5
`define RXS_CONTINUOUS 4
`define RXS_FRAMING 2
`define RXS_OVERRUN 1
`define RXS_NINTH_BIT 0

// irq flag, enable and priority fields
`define IRQ_RX_BIT 5
`define IRQ_TX_BIT 4

// oversampling terminals, count minus one
`define OVERSAMPLE_LOW 6'h0f
`define OVERSAMPLE_HIGH 6'h3f

// bits per word: async after the start bit (data, ninth, stop), sync data and ninth only
`define ASYNC_BITS_8 4'h9
`define ASYNC_BITS_9 4'ha
`define SYNC_BITS_8 4'h8
`define SYNC_BITS_9 4'h9

// remote node register byte offsets
`define NODE_CTRL 4'h0
`define NODE_TX_WORD 4'h4
`define NODE_RX_WORD 4'h8
`define NODE_STATUS 4'hc
`define NODE_EN 0
`define NODE_NINE 1
`define NODE_DRIVE_DT 2
`define NODE_DRIVE_CK 3
`define NODE_CK_HALF 8'h07
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// ---- core/usart_pkg.sv ----
// types used by the serial port end of the link
package usart_pkg;
	typedef enum logic [1:0]
	{
		SH_IDLE = 2'b00,
		SH_TX = 2'b01,
		SH_RX = 2'b10
	} shift_state_e;
endpackage

// ---- core/usart_link_if.sv ----
// two-wire link between the serial port and the remote node
`timescale 1ns/1ps
`default_nettype none
interface usart_link_if;
	// per-end drives of the clock pin
	logic ck_dev_o;
	logic ck_dev_oe;
	logic ck_node_o;
	logic ck_node_oe;
	// per-end drives of the data pin
	logic dt_dev_o;
	logic dt_dev_oe;
	logic dt_node_o;
	logic dt_node_oe;
	// resolved wire levels, pulled up when nobody drives
	logic ck;
	logic dt;
	assign ck = ck_dev_oe ? ck_dev_o : (ck_node_oe ? ck_node_o : 1'b1);
	assign dt = dt_dev_oe ? dt_dev_o : (dt_node_oe ? dt_node_o : 1'b1);
	modport device (output ck_dev_o, output ck_dev_oe, output dt_dev_o, output dt_dev_oe, input ck, input dt);
	modport node (output ck_node_o, output ck_node_oe, output dt_node_o, output dt_node_oe, input ck, input dt);
endinterface
`default_nettype wire

// ---- core/usart_baud_gen.sv ----
// baud generator: base tick from divisor, bit tick after oversampling
`timescale 1ns/1ps
`default_nettype none
`include "usart_defines.svh"
module usart_baud_gen
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic restart,
	input wire logic [7:0] divisor,
	input wire logic high_speed,
	// ticks
	output logic tick,
	output logic bit_tick
);
	logic [7:0] div_cnt;
	logic [5:0] os_cnt;
	logic [5:0] os_top;

	// high speed selects the shorter oversampling chain
	assign os_top = high_speed ? `OVERSAMPLE_LOW : `OVERSAMPLE_HIGH;
	assign tick = (div_cnt == 8'h00) && !restart;
	assign bit_tick = tick && (os_cnt == os_top);

	// divisor down-counter, realigned at each async frame start
	always_ff @(posedge aclk)
	begin
		if (!aresetn || restart || tick)
			div_cnt <= divisor;
		else
			div_cnt <= div_cnt - 8'h01;
	end

	// oversampling counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn || restart || bit_tick)
			os_cnt <= 6'h00;
		else if (tick)
			os_cnt <= os_cnt + 6'h01;
	end
endmodule
`default_nettype wire

// ---- core/usart_device.sv ----
// serial port: async transmitter, sync master and slave shifter
`timescale 1ns/1ps
`default_nettype none
`include "usart_defines.svh"
module usart_device
	import usart_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// interrupt requests
	output logic irq_high,
	output logic irq_low,
	// serial pins
	usart_link_if.device link
);
	// ***************************************************
	// registers
	// ***************************************************
	logic [7:0] txs;
	logic port_enable, rx9, single_receive_enable, continuous_receive_enable, overrun_error, rx_ninth_bit;
	logic [7:0] tx_buffer, rx_buffer, baud_divisor, irq_en, irq_prio;
	logic buf_full, tx_buffer_empty_flag, rx_complete_flag;
	logic [7:0] next_rdata;
	logic wr_txbuf, wr_txs, wr_rxs, rd_rxbuf;
	logic transmit_enable_rise, continuous_receive_enable_fall;

	assign wr_txbuf = reg_wr && (reg_addr == `IDX_TX_BUFFER);
	assign wr_txs = reg_wr && (reg_addr == `IDX_TX_CONTROL_STATUS);
	assign wr_rxs = reg_wr && (reg_addr == `IDX_RX_CONTROL_STATUS);
	assign rd_rxbuf = reg_rd && (reg_addr == `IDX_RX_BUFFER);
	assign transmit_enable_rise = wr_txs && reg_wdata[`TXS_TX_ENABLE] && !txs[`TXS_TX_ENABLE];
	assign continuous_receive_enable_fall = wr_rxs && !reg_wdata[`RXS_CONTINUOUS] && continuous_receive_enable;

	// ***************************************************
	// pin synchronisers and shift engine state
	// ***************************************************
	logic ck_s1, ck_s2, ck_prev, dt_s1, dt_s2;
	shift_state_e state;
	logic [9:0] tx_shift_register;
	logic [8:0] rsr;
	logic [3:0] bitcnt;
	logic line_out, ck_out;
	logic tick, bit_tick, restart;
	logic sync_mode, master, load, rx_start, fall_ev, rx_done;
	logic [8:0] next_rsr;

	assign sync_mode = txs[`TXS_CLOCKED_MODE];
	assign master = txs[`TXS_CLOCK_SOURCE];
	// a write in flight holds off the load, so flag and buffer never disagree
	assign load = (state == SH_IDLE) && buf_full && port_enable && txs[`TXS_TX_ENABLE] && !wr_txbuf;
	assign rx_start = (state == SH_IDLE) && sync_mode && master && port_enable && (single_receive_enable || continuous_receive_enable) && !overrun_error;
	assign restart = load && !sync_mode;

	// master falls come from its own clock, slave falls from the pin
	assign fall_ev = master ? (tick && ck_out) : (!ck_s2 && ck_prev);

	assign next_rsr = {dt_s2, rsr[8:1]};
	assign rx_done = (state == SH_RX) && fall_ev && (bitcnt == 4'h1);

	usart_baud_gen baud
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.restart(restart),
		.divisor(baud_divisor),
		.high_speed(txs[`TXS_HIGH_SPEED]),
		.tick(tick),
		.bit_tick(bit_tick)
	);

	// two flops before any logic looks at a pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ck_s1 <= 1'b1;
			ck_s2 <= 1'b1;
			ck_prev <= 1'b1;
			dt_s1 <= 1'b1;
			dt_s2 <= 1'b1;
		end
		else
		begin
			ck_s1 <= link.ck;
			ck_s2 <= ck_s1;
			ck_prev <= ck_s2;
			dt_s1 <= link.dt;
			dt_s2 <= dt_s1;
		end
	end

	// ***************************************************
	// shift engine: one state so tx and rx exclude each other
	// ***************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= SH_IDLE;
			tx_shift_register <= 10'h3ff;
			rsr <= 9'h000;
			bitcnt <= 4'h0;
			line_out <= 1'b1;
		end
		else
		begin
			case (state)
				SH_IDLE:
				begin
					if (!sync_mode)
						line_out <= 1'b1;
					if (rx_start)
					begin
						state <= SH_RX;
						bitcnt <= rx9 ? `SYNC_BITS_9 : `SYNC_BITS_8;
					end
					else if (load && !sync_mode)
					begin
						state <= SH_TX;
						line_out <= 1'b0; // start bit
						tx_shift_register <= {1'b1, txs[`TXS_NINE_BIT] ? txs[`TXS_NINTH_BIT] : 1'b1, tx_buffer};
						bitcnt <= txs[`TXS_NINE_BIT] ? `ASYNC_BITS_9 : `ASYNC_BITS_8;
					end
					else if (load)
					begin
						state <= SH_TX;
						line_out <= tx_buffer[0];
						tx_shift_register <= {2'b11, txs[`TXS_NINTH_BIT], tx_buffer[7:1]}; // ninth bit follows bit 7
						bitcnt <= txs[`TXS_NINE_BIT] ? (`SYNC_BITS_9 - 4'h1) : (`SYNC_BITS_8 - 4'h1);
					end
				end
				SH_TX:
				begin
					// async steps on bit ticks, sync on clock falls
					if (sync_mode ? fall_ev : bit_tick)
					begin
						if (bitcnt == 4'h0)
						begin
							state <= SH_IDLE; // stop or last bit done
							line_out <= 1'b1;
						end
						else
						begin
							line_out <= tx_shift_register[0]; // lsb first
							tx_shift_register <= {1'b1, tx_shift_register[9:1]};
							bitcnt <= bitcnt - 4'h1;
						end
					end
				end
				SH_RX:
				begin
					if (fall_ev)
					begin
						rsr <= next_rsr;
						bitcnt <= bitcnt - 4'h1;
						if (bitcnt == 4'h1)
							state <= SH_IDLE;
					end
					// dropping both enables aborts the word
					if (!single_receive_enable && !continuous_receive_enable)
						state <= SH_IDLE;
				end
				default:
					state <= SH_IDLE;
			endcase
		end
	end

	// master clock toggles on base ticks, rests low
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !master || (state == SH_IDLE && !ck_out))
			ck_out <= 1'b0;
		else if (tick && (state != SH_IDLE || ck_out))
			ck_out <= !ck_out;
	end

	// pin drives per mode
	always_comb
	begin
		link.ck_dev_o = sync_mode ? ck_out : line_out;
		link.ck_dev_oe = port_enable && (!sync_mode || master);
		link.dt_dev_o = line_out;
		link.dt_dev_oe = port_enable && sync_mode && (state == SH_TX);
	end

	// ***************************************************
	// register writes
	// ***************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			txs <= `TXS_RESET;
			baud_divisor <= 8'h00;
			irq_en <= 8'h00;
			irq_prio <= 8'h00;
			tx_buffer <= 8'h00;
		end
		else
		begin
			if (wr_txs)
				txs <= {reg_wdata[7:2], 1'b0, reg_wdata[0]}; // shift empty is read only
			if (reg_wr && reg_addr == `IDX_BAUD_DIVISOR)
				baud_divisor <= reg_wdata;
			if (reg_wr && reg_addr == `IDX_IRQ_ENABLES)
				irq_en <= reg_wdata;
			if (reg_wr && reg_addr == `IDX_IRQ_PRIORITY)
				irq_prio <= reg_wdata;
			if (wr_txbuf)
				tx_buffer <= reg_wdata;
		end
	end

	// receive control; single mode ends itself after one word
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{port_enable, rx9, single_receive_enable, continuous_receive_enable} <= 4'h0;
		end
		else if (wr_rxs)
		begin
			port_enable <= reg_wdata[`RXS_PORT_ENABLE];
			rx9 <= reg_wdata[`RXS_NINE_BIT];
			single_receive_enable <= reg_wdata[`RXS_SINGLE];
			continuous_receive_enable <= reg_wdata[`RXS_CONTINUOUS];
		end
		else if (rx_done && !continuous_receive_enable)
			single_receive_enable <= 1'b0;
	end

	// buffer occupancy and the tx flag; set wins over clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			buf_full <= 1'b0;
			tx_buffer_empty_flag <= 1'b0;
		end
		else
		begin
			if (wr_txbuf)
				buf_full <= 1'b1;
			else if (load)
				buf_full <= 1'b0;
			if (load || transmit_enable_rise)
				tx_buffer_empty_flag <= 1'b1;
			else if (wr_txbuf)
				tx_buffer_empty_flag <= 1'b0;
		end
	end

	// received word capture, overrun keeps the old word
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rx_buffer <= 8'h00;
			rx_ninth_bit <= 1'b0;
			rx_complete_flag <= 1'b0;
			overrun_error <= 1'b0;
		end
		else
		begin
			if (rx_done && !rx_complete_flag)
			begin
				rx_buffer <= rx9 ? next_rsr[7:0] : next_rsr[8:1];
				rx_ninth_bit <= rx9 ? next_rsr[8] : 1'b0;
			end
			if (rx_done)
				rx_complete_flag <= 1'b1;
			else if (rd_rxbuf)
				rx_complete_flag <= 1'b0;
			if (rx_done && rx_complete_flag)
				overrun_error <= 1'b1;
			else if (continuous_receive_enable_fall)
				overrun_error <= 1'b0;
		end
	end

	// ***************************************************
	// register reads and interrupt requests
	// ***************************************************
	always_comb
	begin
		next_rdata = 8'h00;
		case (reg_addr)
			`IDX_TX_CONTROL_STATUS: next_rdata = {txs[7:2], state != SH_TX, txs[0]};
			`IDX_RX_CONTROL_STATUS: next_rdata = {port_enable, rx9, single_receive_enable, continuous_receive_enable, 2'b00, overrun_error, rx_ninth_bit};
			`IDX_TX_BUFFER: next_rdata = tx_buffer;
			`IDX_RX_BUFFER: next_rdata = rx_buffer;
			`IDX_BAUD_DIVISOR: next_rdata = baud_divisor;
			`IDX_IRQ_FLAGS: next_rdata = {2'b00, rx_complete_flag, tx_buffer_empty_flag, 4'h0};
			`IDX_IRQ_ENABLES: next_rdata = irq_en;
			`IDX_IRQ_PRIORITY: next_rdata = irq_prio;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
	end

	// flags gated by enables, steered by priority
	logic tx_req, rx_req;
	assign tx_req = tx_buffer_empty_flag && irq_en[`IRQ_TX_BIT];
	assign rx_req = rx_complete_flag && irq_en[`IRQ_RX_BIT];
	assign irq_high = (tx_req && irq_prio[`IRQ_TX_BIT]) || (rx_req && irq_prio[`IRQ_RX_BIT]);
	assign irq_low = (tx_req && !irq_prio[`IRQ_TX_BIT]) || (rx_req && !irq_prio[`IRQ_RX_BIT]);
endmodule
`default_nettype wire

// ---- core/usart_node.sv ----
// remote serial node with AXI4-Lite control
`timescale 1ns/1ps
`default_nettype none
`include "usart_defines.svh"
module usart_node
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// serial pins
	usart_link_if.node link
);
	logic aw_hold, w_hold;
	logic [3:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] ctrl;
	logic [8:0] tx_word, rx_word, tx_sh, rx_sh;
	logic rx_valid, do_write;
	logic ck_s1, ck_s2, ck_prev, dt_s1, dt_s2;
	logic [7:0] half_cnt;
	logic ck_o, rise_ev, fall_ev, word_end;
	logic [3:0] rise_cnt, fall_cnt, nbits;

	// ***************************************************
	// axi4-lite slave
	// ***************************************************
	assign awready = !aw_hold;
	assign wready = !w_hold;
	assign arready = !rvalid;
	assign do_write = aw_hold && w_hold && !bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0000_0000;
			bvalid <= 1'b0;
			bresp <= `AXI_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_hold <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_hold <= 1'b1;
				w_data_q <= wstrb[0] ? wdata : 32'h0000_0000;
			end
			if (do_write)
			begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (aw_addr_q == `NODE_RX_WORD) ? `AXI_SLVERR : `AXI_OKAY;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `AXI_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rresp <= `AXI_OKAY;
			case (araddr)
				`NODE_CTRL: rdata <= {28'h0, ctrl};
				`NODE_TX_WORD: rdata <= {23'h0, tx_word};
				`NODE_RX_WORD: rdata <= {23'h0, rx_word};
				`NODE_STATUS: rdata <= {31'h0, rx_valid};
				default:
				begin
					rdata <= 32'h0000_0000;
					rresp <= `AXI_SLVERR;
				end
			endcase
		end
		else if (rready)
			rvalid <= 1'b0;
	end

	// ***************************************************
	// link side
	// ***************************************************
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{ck_s1, ck_s2, ck_prev, dt_s1, dt_s2} <= 5'h1f;
		end
		else
		begin
			ck_s1 <= link.ck;
			ck_s2 <= ck_s1;
			ck_prev <= ck_s2;
			dt_s1 <= link.dt;
			dt_s2 <= dt_s1;
		end
	end

	// own clock for a slave-mode device, free running while enabled
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !ctrl[`NODE_DRIVE_CK] || !ctrl[`NODE_EN])
		begin
			half_cnt <= `NODE_CK_HALF;
			ck_o <= 1'b1;
		end
		else if (half_cnt == 8'h00)
		begin
			half_cnt <= `NODE_CK_HALF;
			ck_o <= !ck_o;
		end
		else
			half_cnt <= half_cnt - 8'h01;
	end

	assign rise_ev = ctrl[`NODE_DRIVE_CK] ? (half_cnt == 8'h00 && !ck_o) : (ck_s2 && !ck_prev);
	assign fall_ev = ctrl[`NODE_DRIVE_CK] ? (half_cnt == 8'h00 && ck_o) : (!ck_s2 && ck_prev);
	assign nbits = ctrl[`NODE_NINE] ? `SYNC_BITS_9 : `SYNC_BITS_8;
	assign word_end = rise_ev && (rise_cnt == nbits - 4'h1);

	// control writes, word shifting; sample on rise, drive after fall
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= 4'h0;
			tx_word <= 9'h000;
			tx_sh <= 9'h1ff;
			rx_sh <= 9'h000;
			rx_word <= 9'h000;
			rise_cnt <= 4'h0;
			fall_cnt <= 4'h0;
		end
		else
		begin
			if (do_write && aw_addr_q == `NODE_CTRL)
				ctrl <= w_data_q[3:0];
			if (do_write && aw_addr_q == `NODE_TX_WORD)
			begin
				tx_word <= w_data_q[8:0];
				tx_sh <= w_data_q[8:0];
				fall_cnt <= 4'h0;
			end
			else if (ctrl[`NODE_EN] && fall_ev)
			begin
				tx_sh <= (fall_cnt == nbits - 4'h1) ? tx_word : {1'b1, tx_sh[8:1]};
				fall_cnt <= (fall_cnt == nbits - 4'h1) ? 4'h0 : fall_cnt + 4'h1;
			end
			if (!ctrl[`NODE_EN])
				rise_cnt <= 4'h0;
			else if (rise_ev)
			begin
				rx_sh <= {dt_s2, rx_sh[8:1]};
				rise_cnt <= word_end ? 4'h0 : rise_cnt + 4'h1;
				if (word_end)
					rx_word <= ctrl[`NODE_NINE] ? {dt_s2, rx_sh[8:1]} : {1'b0, dt_s2, rx_sh[8:2]};
			end
		end
	end

	// sticky word flag, write one to clear, set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rx_valid <= 1'b0;
		else if (ctrl[`NODE_EN] && word_end)
			rx_valid <= 1'b1;
		else if (do_write && aw_addr_q == `NODE_STATUS && w_data_q[0])
			rx_valid <= 1'b0;
	end

	assign link.ck_node_o = ck_o;
	assign link.ck_node_oe = ctrl[`NODE_EN] && ctrl[`NODE_DRIVE_CK];
	assign link.dt_node_o = tx_sh[0];
	assign link.dt_node_oe = ctrl[`NODE_EN] && ctrl[`NODE_DRIVE_DT];
endmodule
`default_nettype wire

// ---- sim/usart_link_chk.sv ----
// link checker watching both ends of the serial link
`timescale 1ns/1ps
`default_nettype none
module usart_link_chk
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link drives and wires
	input wire logic ck_dev_o,
	input wire logic ck_dev_oe,
	input wire logic ck_node_o,
	input wire logic ck_node_oe,
	input wire logic dt_dev_o,
	input wire logic dt_dev_oe,
	input wire logic dt_node_o,
	input wire logic dt_node_oe,
	input wire logic ck,
	input wire logic dt
);
	// ****************************************
	// link timing, divisor three on the bench
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// high phase of the master clock: four cycles, then low again
	sequence high_phase;
		$stable(ck_dev_o)[*3] ##1 $fell(ck_dev_o);
	endsequence
	AST_RESET_RELEASE: assert property ($rose(aresetn) |-> !ck_dev_oe && !dt_dev_oe && ck_dev_o)
		else $error("pins not released at mark level by reset");
	AST_MIN_RUN: assert property (ck_dev_oe && $past(ck_dev_oe) && $changed(ck_dev_o) |=> $stable(ck_dev_o)[*3])
		else $error("clock pin level shorter than four cycles");
	AST_HALF_EXACT: assert property ($rose(ck_dev_o) && dt_dev_oe |=> high_phase)
		else $error("master clock high phase not four cycles");
	AST_DT_ON_LOW: assert property (dt_dev_oe && $past(dt_dev_oe) && $changed(dt_dev_o) |-> !ck_dev_o)
		else $error("data changed while clock high");
	AST_DT_LOAD_LOW: assert property ($rose(dt_dev_oe) |-> ck_dev_oe && !ck_dev_o)
		else $error("data driven without the clock resting low");
	AST_DT_NEXT_OR_FREE: assert property ($fell(ck_dev_o) && dt_dev_oe |-> ##[1:4] ($rose(ck_dev_o) || !dt_dev_oe))
		else $error("no next bit and no release after a clock fall");
	AST_HALF_DUPLEX: assert property (!(dt_dev_oe && dt_node_oe))
		else $error("both ends drive the data wire");
	AST_NODE_QUIET: assert property (ck_dev_oe |-> !ck_node_oe && ck == ck_dev_o)
		else $error("clock wire not owned by the device");
endmodule
`default_nettype wire

// ---- sim/usart_tx_and_sync_master_tb.sv ----
// self-checking bench for the serial port facing the remote node
`timescale 1ns/1ps
`default_nettype none
`include "usart_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module usart_tx_and_sync_master_tb;
	// ****************************************
	// stimulus, tasks and scenarios
	// ****************************************
	int mismatches = 0;
	int comparisons = 0;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [2:0] reg_addr = 3'h0;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic irq_high, irq_low;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	usart_link_if usart_link_if_i();
	usart_device usart_device_i (.aclk(aclk), .aresetn(aresetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq_high(irq_high), .irq_low(irq_low),
		.link(usart_link_if_i));
	usart_node usart_node_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(usart_link_if_i));
	usart_link_chk usart_link_chk_i (.aclk(aclk), .aresetn(aresetn), .ck_dev_o(usart_link_if_i.ck_dev_o),
		.ck_dev_oe(usart_link_if_i.ck_dev_oe), .ck_node_o(usart_link_if_i.ck_node_o),
		.ck_node_oe(usart_link_if_i.ck_node_oe), .dt_dev_o(usart_link_if_i.dt_dev_o),
		.dt_dev_oe(usart_link_if_i.dt_dev_oe), .dt_node_o(usart_link_if_i.dt_node_o),
		.dt_node_oe(usart_link_if_i.dt_node_oe), .ck(usart_link_if_i.ck), .dt(usart_link_if_i.dt));
	// 40 MHz clock
	initial
	begin
		forever #12.5 aclk = ~aclk;
	end
	// verdict and end of run
	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// register write, strobe for one cycle
	task automatic dwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge aclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge aclk);
		reg_wr <= 1'b0;
	endtask
	// register read and compare; data lands one cycle after the strobe
	task automatic dchk(input logic [2:0] a, input logic [7:0] e);
		@(posedge aclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge aclk);
		reg_rd <= 1'b0;
		@(posedge aclk);
		`CHK(reg_rdata, e)
	endtask
	// poll a register until all bits of the mask are seen
	task automatic dpoll(input logic [2:0] a, input logic [7:0] m);
		logic [7:0] v;
		v = 8'h00;
		repeat (300)
			if ((v & m) !== m)
			begin
				@(posedge aclk);
				reg_addr <= a;
				reg_rd <= 1'b1;
				@(posedge aclk);
				reg_rd <= 1'b0;
				@(posedge aclk);
				v = reg_rdata;
			end
		`CHK(v & m, m)
	endtask
	// axi write: address and data offered together, each released when taken
	task automatic awr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
		`CHK(bresp, r)
	endtask
	// axi read
	task automatic ard(input logic [3:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
	endtask
	// wait for a word at the node, compare it, clear the sticky flag
	task automatic nword(input logic [8:0] e);
		logic [31:0] d;
		d = 32'h0;
		repeat (100)
			if (d[0] !== 1'b1)
				ard(`NODE_STATUS, d);
		`CHK(d[0], 1'b1)
		ard(`NODE_RX_WORD, d);
		`CHK(d[8:0], e)
		awr(`NODE_STATUS, 32'h1, `AXI_OKAY);
	endtask
	// catch an async frame on the clock pin, sampling each bit in its middle
	task automatic grab(input int n, input int len, output logic [10:0] f);
		f = 11'h000;
		repeat (3000)
			if (usart_link_if_i.ck === 1'b1)
				@(posedge aclk);
		for (int i = 0; i < n; i++)
		begin
			repeat ((i == 0) ? len / 2 : len) @(posedge aclk);
			f[i] = usart_link_if_i.ck;
		end
	endtask
	// hang guard, far above the few thousand cycles the run needs
	initial
	begin
		#1000000;
		mismatches++;
		wrap_up();
	end
	// main sequence
	initial
	begin
		logic [10:0] f, g;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++)
			dchk(i[2:0], (i == 0) ? `TXS_RESET : 8'h00);
		// async setup in the documented order, x16 with divisor three
		dwr(`IDX_BAUD_DIVISOR, 8'h03);
		dwr(`IDX_TX_CONTROL_STATUS, 8'h04);
		dwr(`IDX_RX_CONTROL_STATUS, 8'h80);
		dwr(`IDX_IRQ_ENABLES, 8'h10);
		dwr(`IDX_IRQ_PRIORITY, 8'h10);
		dchk(`IDX_IRQ_FLAGS, 8'h00);
		dwr(`IDX_TX_CONTROL_STATUS, 8'h24);
		dchk(`IDX_IRQ_FLAGS, 8'h10);
		`CHK(irq_high, 1'b1)
		dwr(`IDX_IRQ_FLAGS, 8'h00);
		dchk(`IDX_IRQ_FLAGS, 8'h10);
		dwr(`IDX_IRQ_ENABLES, 8'h00);
		dchk(`IDX_IRQ_ENABLES, 8'h00);
		`CHK(irq_high, 1'b0)
		// two words back to back; the second waits for the first stop bit
		fork
			begin
				grab(10, 64, f);
				grab(10, 64, g);
			end
			begin
				dwr(`IDX_TX_BUFFER, 8'ha5);
				dwr(`IDX_TX_BUFFER, 8'h3c);
				dchk(`IDX_IRQ_FLAGS, 8'h00);
				dchk(`IDX_TX_CONTROL_STATUS, 8'h24);
			end
		join
		`CHK(f[9:0], {1'b1, 8'ha5, 1'b0})
		`CHK(g[9:0], {1'b1, 8'h3c, 1'b0})
		repeat (64) @(posedge aclk);
		`CHK(usart_link_if_i.ck, 1'b1)
		dchk(`IDX_TX_CONTROL_STATUS, 8'h26);
		dchk(`IDX_IRQ_FLAGS, 8'h10);
		// nine bits with a set ninth bit, x64 oversampling
		dwr(`IDX_TX_CONTROL_STATUS, 8'h61);
		fork
			grab(11, 256, f);
			dwr(`IDX_TX_BUFFER, 8'h0f);
		join
		`CHK(f, {1'b1, 1'b1, 8'h0f, 1'b0})
		// reset in mid-run, then sync master transmit to the node
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		dchk(`IDX_TX_CONTROL_STATUS, `TXS_RESET);
		dwr(`IDX_BAUD_DIVISOR, 8'h03);
		dwr(`IDX_TX_CONTROL_STATUS, 8'hb0);
		dwr(`IDX_RX_CONTROL_STATUS, 8'h80);
		awr(`NODE_CTRL, 32'h1, `AXI_OKAY);
		dwr(`IDX_TX_BUFFER, 8'h96);
		dwr(`IDX_TX_BUFFER, 8'h5a);
		`CHK(usart_link_if_i.ck_dev_oe, 1'b1)
		nword(8'h96);
		nword(8'h5a);
		`CHK(usart_link_if_i.dt_dev_oe, 1'b0)
		awr(`NODE_RX_WORD, 32'h0, `AXI_SLVERR);
		// nine-bit master word, ninth bit last on the wire
		dwr(`IDX_TX_CONTROL_STATUS, 8'hf1);
		awr(`NODE_CTRL, 32'h3, `AXI_OKAY);
		dwr(`IDX_TX_BUFFER, 8'h69);
		nword(9'h169);
		// sync master receive: nine-bit single word, then continuous over single
		awr(`NODE_TX_WORD, 32'h1c3, `AXI_OKAY);
		awr(`NODE_CTRL, 32'h7, `AXI_OKAY);
		dwr(`IDX_IRQ_ENABLES, 8'h20);
		dwr(`IDX_RX_CONTROL_STATUS, 8'he0);
		dpoll(`IDX_IRQ_FLAGS, 8'h20);
		`CHK(irq_low, 1'b1)
		dchk(`IDX_RX_CONTROL_STATUS, 8'hc1);
		dchk(`IDX_RX_BUFFER, 8'hc3);
		dchk(`IDX_IRQ_FLAGS, 8'h10);
		awr(`NODE_CTRL, 32'h5, `AXI_OKAY);
		dwr(`IDX_RX_CONTROL_STATUS, 8'hb0);
		dpoll(`IDX_IRQ_FLAGS, 8'h20);
		dchk(`IDX_RX_BUFFER, 8'hc3);
		dpoll(`IDX_RX_CONTROL_STATUS, 8'h02);
		dwr(`IDX_RX_CONTROL_STATUS, 8'h80);
		dchk(`IDX_RX_CONTROL_STATUS, 8'h80);
		awr(`NODE_CTRL, 32'h1, `AXI_OKAY);
		// slave mode leaves the clock wire to the outside
		dwr(`IDX_TX_CONTROL_STATUS, 8'h30);
		dchk(`IDX_TX_CONTROL_STATUS, 8'h32);
		`CHK(usart_link_if_i.ck_dev_oe, 1'b0)
		wrap_up();
	end
endmodule
`default_nettype wire
